// ==== hw/eebp_host.sv ====
/*
  host controller driving a byte-wide eeprom over its parallel pins:
  reads, byte/page writes, completion wait by data polling, hold-off.
  assumes the eeprom pins are synchronous to clk; data pins are split
  into in/out/enable, resolved outside.
*/
// Notes on behaviour
// - the host waits the full program cycle after a write unless polling sees completion.
// - page bytes are strobed 1 us to 30 us apart so they form one load.
// - the host waits 100 us after raising hold_off_n before the first write.
// - each write strobe is held low at least 250 ns, covering both grades.
`timescale 1ns/1ps
`default_nettype none
`include "eebp_defines.svh"
module eebp_host
    import eebp_pkg::*;
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // user commands and status
    input  wire logic                     enable,
    input  wire logic                     rd_req,
    input  wire logic                     pg_wr_req,
    input  wire logic [`EEBP_ADDR_W-1:0]  user_addr,
    input  wire logic [7:0]               pg_len_m1,
    input  wire logic                     fill_en,
    input  wire logic [6:0]               fill_idx,
    input  wire logic [7:0]               fill_data,
    output logic                          ready,
    output logic                          rd_valid,
    output logic [7:0]                    rd_data,
    output logic                          wr_done,
    // eeprom pins
    output logic [`EEBP_ADDR_W-1:0]       byte_address_lines,
    output logic                          chip_select_n,
    output logic                          output_gate_n,
    output logic                          write_strobe_n,
    output logic                          hold_off_n,
    output logic [7:0]                    data_pins_o,
    output logic                          data_pins_oe,
    input  wire logic [7:0]               data_pins_i,
    input  wire logic                     program_done_flag
);
    eebp_state_t             state_r;
    logic [`EEBP_CNT_W-1:0]  cnt_r;
    logic [`EEBP_CNT_W-1:0]  busy_cnt_r;
    logic [6:0]              idx_r;
    logic [6:0]              last_r;
    logic [7:0]              last_byte_r;
    logic [9:0]              page_r;
    logic [7:0]              buf_q;

    function automatic logic [`EEBP_CNT_W-1:0] cyc(input integer n);
        cyc = `EEBP_CNT_W'(n);
    endfunction

    eebp_page_buf u_buf (
        .clk     (clk),
        .wr_en   (fill_en & ready),
        .wr_idx  (fill_idx),
        .wr_data (fill_data),
        .rd_idx  (idx_r),
        .rd_data (buf_q)
    );

    // main sequencer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r            <= EEBP_S_HOLD;
            cnt_r              <= '0;
            busy_cnt_r         <= '0;
            idx_r              <= '0;
            last_r             <= '0;
            last_byte_r        <= 8'h00;
            page_r             <= '0;
            ready              <= 1'b0;
            rd_valid           <= 1'b0;
            rd_data            <= 8'h00;
            wr_done            <= 1'b0;
            byte_address_lines <= '0;
            chip_select_n      <= 1'b1;
            output_gate_n      <= 1'b1;
            write_strobe_n     <= 1'b1;
            hold_off_n         <= 1'b0;
            data_pins_o        <= 8'h00;
            data_pins_oe       <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            wr_done  <= 1'b0;
            if (busy_cnt_r != '0) begin
                busy_cnt_r <= busy_cnt_r - cyc(1);
            end
            case (state_r)
                EEBP_S_HOLD: begin
                    // pins idle and hold-off low keeps the part protected
                    chip_select_n  <= 1'b1;
                    write_strobe_n <= 1'b1;
                    output_gate_n  <= 1'b1;
                    data_pins_oe   <= 1'b0;
                    hold_off_n     <= 1'b0;
                    ready          <= 1'b0;
                    if (enable) begin
                        hold_off_n <= 1'b1;
                        cnt_r      <= cyc(`EEBP_HOLDOFF_CYC);
                        state_r    <= EEBP_S_RELEASE;
                    end
                end
                EEBP_S_RELEASE: begin
                    if (cnt_r == cyc(1)) begin
                        ready   <= 1'b1;
                        state_r <= EEBP_S_IDLE;
                    end
                    cnt_r <= cnt_r - cyc(1);
                end
                EEBP_S_IDLE: begin
                    if (!enable) begin
                        // dropping enable is only seen in idle, after any program has finished
                        ready   <= 1'b0;
                        state_r <= EEBP_S_HOLD;
                    end else if (pg_wr_req) begin
                        ready              <= 1'b0;
                        page_r             <= user_addr[16:7];
                        idx_r              <= user_addr[6:0];
                        last_r             <= user_addr[6:0] + pg_len_m1[6:0];
                        // two cycles: idx_r lands first, then the buffer registers its byte
                        cnt_r              <= cyc(2);
                        state_r            <= EEBP_S_WR_GAP;
                    end else if (rd_req) begin
                        ready              <= 1'b0;
                        byte_address_lines <= user_addr;
                        chip_select_n      <= 1'b0;
                        output_gate_n      <= 1'b0;
                        cnt_r              <= cyc(`EEBP_ACCESS_CYC);
                        state_r            <= EEBP_S_RD_WAIT;
                    end
                end
                EEBP_S_RD_WAIT: begin
                    cnt_r <= cnt_r - cyc(1);
                    if (cnt_r == cyc(1)) begin
                        rd_data       <= data_pins_i;
                        rd_valid      <= 1'b1;
                        chip_select_n <= 1'b1;
                        output_gate_n <= 1'b1;
                        ready         <= 1'b1;
                        state_r       <= EEBP_S_IDLE;
                    end
                end
                EEBP_S_WR_GAP: begin
                    // buffer read data has settled one cycle after idx change
                    cnt_r <= cnt_r - cyc(1);
                    if (cnt_r == cyc(1)) begin
                        byte_address_lines <= {page_r, idx_r};
                        data_pins_o        <= buf_q;
                        last_byte_r        <= buf_q;
                        data_pins_oe       <= 1'b1;
                        chip_select_n      <= 1'b0;
                        output_gate_n      <= 1'b1;
                        write_strobe_n     <= 1'b0;
                        cnt_r              <= cyc(`EEBP_STROBE_CYC);
                        state_r            <= EEBP_S_WR_LOW;
                    end
                end
                EEBP_S_WR_LOW: begin
                    cnt_r <= cnt_r - cyc(1);
                    if (cnt_r == cyc(1)) begin
                        write_strobe_n <= 1'b1;
                        chip_select_n  <= 1'b1;
                        if (idx_r == last_r) begin
                            // full cycle bound; polling may finish it sooner
                            busy_cnt_r <= cyc(`EEBP_PROG_CYCLE_CYC);
                            cnt_r      <= cyc(`EEBP_ACCESS_CYC);
                            state_r    <= EEBP_S_BUSY;
                        end else begin
                            // spacing set at the 1 us minimum of the 1..30 us window between strobes
                            idx_r   <= idx_r + 7'h01;
                            cnt_r   <= cyc(`EEBP_SPACING_MIN_CYC);
                            state_r <= EEBP_S_WR_GAP;
                        end
                    end
                end
                EEBP_S_BUSY: begin
                    data_pins_oe <= 1'b0;
                    cnt_r        <= cnt_r - cyc(1);
                    if (busy_cnt_r == '0) begin
                        wr_done <= 1'b1;
                        ready   <= 1'b1;
                        state_r <= EEBP_S_IDLE;
                    end else if (cnt_r == cyc(1)) begin
                        // polls inside the load window only read busy status, so they start early
                        chip_select_n <= 1'b0;
                        output_gate_n <= 1'b0;
                        cnt_r         <= cyc(`EEBP_ACCESS_CYC);
                        state_r       <= EEBP_S_POLL;
                    end
                end
                EEBP_S_POLL: begin
                    cnt_r <= cnt_r - cyc(1);
                    if (cnt_r == cyc(1)) begin
                        chip_select_n <= 1'b1;
                        output_gate_n <= 1'b1;
                        // true bit 7 back with program_done_flag high means the internal write is over
                        if (data_pins_i[7] == last_byte_r[7] && program_done_flag) begin
                            wr_done <= 1'b1;
                            ready   <= 1'b1;
                            state_r <= EEBP_S_IDLE;
                        end else begin
                            cnt_r   <= cyc(`EEBP_ACCESS_CYC);
                            state_r <= EEBP_S_POLL_HI;
                        end
                    end
                end
                EEBP_S_POLL_HI: begin
                    cnt_r <= cnt_r - cyc(1);
                    if (cnt_r == cyc(1)) begin
                        cnt_r   <= cyc(1);
                        state_r <= EEBP_S_BUSY;
                    end
                end
                default: begin
                    state_r <= EEBP_S_HOLD;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== hw/eebp_defines.svh ====
/*
  timing counts and widths for the eeprom page host controller.
  assumes a 20 MHz system clock (50 ns period).
*/
`ifndef EEBP_DEFINES_SVH
`define EEBP_DEFINES_SVH

`define EEBP_CLK_NS              50
`define EEBP_ADDR_W              17
`define EEBP_PAGE_BYTES          128
`define EEBP_PAGE_IDX_W          7
// program cycle time, ms
`define EEBP_PROG_CYCLE_MS       15
`define EEBP_PROG_CYCLE_CYC      ((`EEBP_PROG_CYCLE_MS * 1000000) / `EEBP_CLK_NS)
// byte spacing, us (min and max)
`define EEBP_SPACING_MIN_US      1
`define EEBP_SPACING_MAX_US      30
`define EEBP_SPACING_MIN_CYC     ((`EEBP_SPACING_MIN_US * 1000 + `EEBP_CLK_NS - 1) / `EEBP_CLK_NS)
`define EEBP_SPACING_MAX_CYC     ((`EEBP_SPACING_MAX_US * 1000) / `EEBP_CLK_NS)
// hold-off release wait, us
`define EEBP_HOLDOFF_US          100
`define EEBP_HOLDOFF_CYC         ((`EEBP_HOLDOFF_US * 1000 + `EEBP_CLK_NS - 1) / `EEBP_CLK_NS)
// strobe low width, ns (slower grade covers both)
`define EEBP_STROBE_NS           250
`define EEBP_STROBE_CYC          ((`EEBP_STROBE_NS + `EEBP_CLK_NS - 1) / `EEBP_CLK_NS)
// read access, ns (slower grade)
`define EEBP_ACCESS_NS           250
`define EEBP_ACCESS_CYC          ((`EEBP_ACCESS_NS + `EEBP_CLK_NS - 1) / `EEBP_CLK_NS)
`define EEBP_CNT_W               20

`endif

// ==== hw/eebp_pkg.sv ====
/*
  types for the eeprom page host controller.
  assumes eebp_defines.svh is on the include path.
*/
package eebp_pkg;
    typedef enum logic [3:0] {
        EEBP_S_HOLD    = 4'h0,
        EEBP_S_RELEASE = 4'h1,
        EEBP_S_IDLE    = 4'h2,
        EEBP_S_RD_WAIT = 4'h3,
        EEBP_S_WR_LOW  = 4'h4,
        EEBP_S_WR_GAP  = 4'h5,
        EEBP_S_BUSY    = 4'h6,
        EEBP_S_POLL    = 4'h7,
        EEBP_S_POLL_HI = 4'h8
    } eebp_state_t;
endpackage

// ==== hw/eebp_page_buf.sv ====
/*
  128 x 8 page buffer with registered read data.
  assumes single clock, one write and one read port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eebp_defines.svh"
module eebp_page_buf
    import eebp_pkg::*;
(
    // clock
    input  wire logic                         clk,
    // write side
    input  wire logic                         wr_en,
    input  wire logic [`EEBP_PAGE_IDX_W-1:0]  wr_idx,
    input  wire logic [7:0]                   wr_data,
    // read side
    input  wire logic [`EEBP_PAGE_IDX_W-1:0]  rd_idx,
    output logic      [7:0]                   rd_data
);
    logic [7:0] mem [0:`EEBP_PAGE_BYTES-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
        rd_data <= mem[rd_idx];
    end
endmodule
`default_nettype wire

// ==== tb/eebp_host_chk.sv ====
/* pin-level checker for the eeprom host controller.
   assumes it is bound into eebp_host and runs on its clock. */
`timescale 1ns/1ps
`default_nettype none
`include "eebp_defines.svh"
module eebp_host_chk
    import eebp_pkg::*;
(
    // clock and reset
    input wire logic                    clk,
    input wire logic                    reset_n,
    // user side
    input wire logic                    enable,
    input wire logic                    rd_req,
    input wire logic                    pg_wr_req,
    input wire logic                    ready,
    input wire logic                    rd_valid,
    input wire logic                    wr_done,
    // eeprom pins
    input wire logic [`EEBP_ADDR_W-1:0] byte_address_lines,
    input wire logic                    chip_select_n,
    input wire logic                    output_gate_n,
    input wire logic                    write_strobe_n,
    input wire logic                    hold_off_n,
    input wire logic                    data_pins_oe,
    input wire logic                    program_done_flag
);
    logic [11:0] rel_r;
    logic [9:0]  gap_r;
    logic [9:0]  page_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // counters saturate so a long idle never wraps into a false pass
    always_ff @(posedge clk) begin
        if (!reset_n || !hold_off_n) rel_r <= 12'h000;
        else if (rel_r != 12'hFFF) rel_r <= rel_r + 12'h001;
    end
    always_ff @(posedge clk) begin
        if (!reset_n) gap_r <= 10'h3FF;
        else if (!write_strobe_n) gap_r <= 10'h000;
        else if (gap_r != 10'h3FF) gap_r <= gap_r + 10'h001;
    end
    always_ff @(posedge clk) begin
        if (!write_strobe_n) page_r <= byte_address_lines[16:7];
    end
    a_holdoff_wait: assert property (!write_strobe_n |-> rel_r >= 12'h7D0) else $error("write too soon");
    a_strobe_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*5]) else $error("strobe short");
    a_byte_spacing: assert property ($fell(write_strobe_n) && gap_r != 10'h3FF |-> gap_r >= 10'h00F && gap_r <= 10'h253)
        else $error("byte spacing");
    a_page_fixed: assert property ($fell(write_strobe_n) && gap_r != 10'h3FF |-> byte_address_lines[16:7] == page_r)
        else $error("page moved");
    a_write_mode: assert property (!write_strobe_n |-> !chip_select_n && output_gate_n && hold_off_n && data_pins_oe)
        else $error("bad write mode");
    a_read_mode: assert property (!output_gate_n |-> !chip_select_n && write_strobe_n && !data_pins_oe)
        else $error("bad read mode");
    a_read_answer: assert property (ready && enable && rd_req && !pg_wr_req |-> ##6 rd_valid) else $error("late read");
    a_done_flag: assert property (wr_done |-> $past(program_done_flag)) else $error("done while busy");
    a_hold_quiet: assert property (!hold_off_n |-> !ready && write_strobe_n) else $error("access in hold");
endmodule
bind eebp_host eebp_host_chk u_chk (.clk, .reset_n, .enable, .rd_req, .pg_wr_req, .ready, .rd_valid, .wr_done,
    .byte_address_lines, .chip_select_n, .output_gate_n, .write_strobe_n, .hold_off_n, .data_pins_oe,
    .program_done_flag);
`default_nettype wire

// ==== tb/eebp_eeprom_model.sv ====
/* behavioural byte-wide eeprom answering the host controller.
   assumes pins sampled on clk; the bench resolves data and flag wires. */
`timescale 1ns/1ps
`default_nettype none
`include "eebp_defines.svh"
module eebp_eeprom_model
    import eebp_pkg::*;
#(
    parameter int WIN_CYC  = 2000,
    parameter int PROG_CYC = 400
)
(
    // clock
    input  wire logic                    clk,
    // host pins
    input  wire logic [`EEBP_ADDR_W-1:0] byte_address_lines,
    input  wire logic                    chip_select_n,
    input  wire logic                    output_gate_n,
    input  wire logic                    write_strobe_n,
    input  wire logic                    hold_off_n,
    input  wire logic [7:0]              data_pins_o,
    // device drive
    output logic [7:0]                   dev_q,
    output logic                         dev_oe,
    output logic                         dev_busy
);
    logic [7:0]              mem [0:(1<<`EEBP_ADDR_W)-1];
    logic [7:0]              last_r = 8'hFF;
    logic [7:0]              lat_d_r;
    logic [`EEBP_ADDR_W-1:0] lat_a_r;
    logic                    load_r = 1'b0;
    logic                    busy_r = 1'b0;
    int                      idle_r = 0;
    initial for (int i = 0; i < (1 << `EEBP_ADDR_W); i++) mem[i] = 8'hFF;
    assign dev_oe   = !chip_select_n && !output_gate_n && write_strobe_n && hold_off_n;
    assign dev_q    = busy_r ? {~last_r[7], mem[byte_address_lines][6:0]} : mem[byte_address_lines];
    assign dev_busy = busy_r && hold_off_n;
    always @(posedge clk) begin
        if (!hold_off_n) begin
            load_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (!chip_select_n && output_gate_n && !write_strobe_n) begin
            lat_d_r <= data_pins_o;
            lat_a_r <= byte_address_lines;
            load_r  <= 1'b1;
            busy_r  <= 1'b1;
            idle_r  <= 0;
        end else if (load_r) begin
            mem[lat_a_r] <= lat_d_r;
            last_r       <= lat_d_r;
            load_r       <= 1'b0;
        end else if (busy_r) begin
            idle_r <= idle_r + 1;
            // window first, then a short program time well inside 15 ms
            if (idle_r == WIN_CYC + PROG_CYC) busy_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== tb/eebp_host_test.sv ====
/* self-checking bench for the eeprom host controller.
   assumes the model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "eebp_defines.svh"
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t got %h expected %h", $time, g, e); end end
module eebp_host_test
    import eebp_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, enable = 1'b0, rd_req = 1'b0, pg_wr_req = 1'b0, fill_en = 1'b0;
    logic [16:0] user_addr = 17'h00000;
    logic [7:0]  pg_len_m1 = 8'h00, fill_data = 8'h00, rd_data, data_pins_o, data_pins_i, dev_q, d;
    logic [7:0]  float_r = 8'h5A;
    logic [6:0]  fill_idx = 7'h00;
    logic [16:0] byte_address_lines;
    logic ready, rd_valid, wr_done, chip_select_n, output_gate_n, write_strobe_n, hold_off_n;
    logic data_pins_oe, program_done_flag, dev_oe, dev_busy;
    int   bad_count = 0, samples_checked = 0;
    always #25 clk = ~clk;
    // a floating bus must not look like the last byte, so it toggles
    always @(posedge clk) float_r <= ~float_r;
    assign data_pins_i = data_pins_oe ? data_pins_o : (dev_oe ? dev_q : float_r);
    assign program_done_flag = !dev_busy;
    eebp_host u_dut (.clk, .reset_n, .enable, .rd_req, .pg_wr_req, .user_addr, .pg_len_m1, .fill_en, .fill_idx,
        .fill_data, .ready, .rd_valid, .rd_data, .wr_done, .byte_address_lines, .chip_select_n, .output_gate_n,
        .write_strobe_n, .hold_off_n, .data_pins_o, .data_pins_oe, .data_pins_i, .program_done_flag);
    eebp_eeprom_model u_mem (.clk, .byte_address_lines, .chip_select_n, .output_gate_n, .write_strobe_n,
        .hold_off_n, .data_pins_o, .dev_q, .dev_oe, .dev_busy);
    task automatic wait_for(input int sel, input int lim);
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while ((sel == 0 ? ready : sel == 1 ? rd_valid : wr_done) !== 1'b1 && n < lim);
        if (n >= lim) begin bad_count++; summarize(); end
    endtask
    task automatic read_byte(input logic [16:0] a);
        wait_for(0, 9000);
        @(posedge clk); rd_req <= 1'b1; user_addr <= a;
        @(posedge clk); rd_req <= 1'b0;
        wait_for(1, 20);
        d = rd_data;
    endtask
    task automatic page_write(input logic [16:0] a, input logic [7:0] len, input logic [7:0] base);
        wait_for(0, 9000);
        for (int i = 0; i <= len; i++) begin
            @(posedge clk); fill_en <= 1'b1; fill_idx <= a[6:0] + 7'(i); fill_data <= base + 8'(i);
        end
        @(posedge clk); fill_en <= 1'b0; pg_wr_req <= 1'b1; user_addr <= a; pg_len_m1 <= len;
        @(posedge clk); pg_wr_req <= 1'b0;
        wait_for(2, 9000);
        `CHECK(program_done_flag, 1'b1)
    endtask
    task automatic test_release();
        @(negedge clk);
        `CHECK(hold_off_n, 1'b0)
        @(posedge clk); enable <= 1'b1;
        repeat (1990) @(negedge clk);
        `CHECK(ready, 1'b0)
        wait_for(0, 100);
        $display("test release done");
    endtask
    task automatic test_page(input logic [16:0] a, input logic [7:0] len, input logic [7:0] base);
        page_write(a, len, base);
        for (int i = 0; i <= len; i++) begin
            read_byte({a[16:7], a[6:0] + 7'(i)});
            `CHECK(d, base + 8'(i))
        end
        read_byte({a[16:7], a[6:0] + 7'(len) + 7'h01});
        if (len < 8'h7F) `CHECK(d, 8'hFF)
        `CHECK(chip_select_n, 1'b1)
        $display("test page done");
    endtask
    task automatic test_holdoff();
        wait_for(0, 9000);
        @(posedge clk); enable <= 1'b0;
        repeat (3) @(negedge clk);
        `CHECK({hold_off_n, ready}, 2'b00)
        @(posedge clk); enable <= 1'b1;
        read_byte(17'h002FE);
        `CHECK(d, 8'h7E)
        $display("test holdoff done");
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        test_release();
        test_page(17'h002FE, 8'h03, 8'h7E);
        test_page(17'h1FF80, 8'h00, 8'h00);
        test_page(17'h00100, 8'h7F, 8'h80);
        test_holdoff();
        summarize();
    end
endmodule
`default_nettype wire
